// [logic/tia_pkg.sv]
// Package for the two-level interrupt arbiter: addresses, reset values,
// field positions, timing counts and the carrier structs.
// Assumes a single system clock shared with the core and the peripherals.
package tia_pkg;

  // Special-function addresses of the two registers held here
  localparam logic [7:0]  ENABLE_ADDR   = 8'hA8;
  localparam logic [7:0]  PRIO_ADDR     = 8'hB8;
  localparam logic [7:0]  ENABLE_RST    = 8'h00;
  localparam logic [7:0]  PRIO_RST      = 8'h00;
  localparam logic [7:0]  PRIO_RD_FIXED = 8'h80;
  localparam logic [7:0]  UNMAPPED_RD   = 8'h00;

  // Field positions
  localparam int          GLOBAL_EN_BIT = 7;
  localparam int          PRIMARY_SRCS  = 7;

  // Sources, order numbers 0 to 14
  localparam int          NUM_SRC       = 15;
  localparam int          IDX_W         = 4;
  localparam int          HW_CLR_SRCS   = 4;

  // Vector table
  localparam logic [15:0] RESET_VEC     = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STEP      = 16'h0008;

  // Response timing in system clocks
  localparam int          DETECT_CYC    = 1;
  localparam int          CALL_CYC      = 4;
  localparam int          RETI_CYC      = 5;
  localparam int          DIV_CYC       = 8;
  localparam int          WORST_CYC     =
    DETECT_CYC + RETI_CYC + DIV_CYC + CALL_CYC;
  localparam logic [1:0]  CALL_LAST     = 2'(CALL_CYC - 1);

  // Register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } tia_sfr_s;

  // Pending flags of the peripheral sources, several owning more than one
  typedef struct packed {
    logic [1:0] uart;
    logic [1:0] timer2;
    logic [3:0] spi;
    logic       twowire_flag;
    logic       adc_window;
    logic       adc_done;
    logic [3:0] pca;
    logic [1:0] comparator;
    logic [1:0] timer3;
  } tia_flags_s;

  // Arbiter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } tia_state_e;

endpackage : tia_pkg

// [logic/tia_arbiter.sv]
// Two-level interrupt arbiter: enable and priority registers, per-cycle
// priority decode, long-call sequencing, in-service tracking.
// Assumes the core, the peripherals and the flag owners share ref_clk;
// every flag input is a registered level from the same clock domain.
`timescale 1ns/1ps

module tia_arbiter (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // Register access from the core
  input  wire tia_pkg::tia_sfr_s  sfr,
  output logic [7:0]              sfr_rdata_q,
  // Extended enable and priority, held elsewhere
  input  wire logic [7:0]         enable_mask_extended,
  input  wire logic [7:0]         priority_level_extended,
  // Single-flag sources
  input  wire logic               ext_input0_pending,
  input  wire logic               timer0_overflow_flag,
  input  wire logic               ext_input1_pending,
  input  wire logic               timer1_overflow_flag,
  // Peripheral sources, some multi-flag
  input  wire tia_pkg::tia_flags_s flags,
  // Core sequencer
  input  wire logic               instr_end,
  input  wire logic               reti_done,
  output logic                    call_busy_q,
  output logic [15:0]             call_vec_q,
  output logic                    call_start_q,
  // Flag clears and status
  output logic [3:0]              hw_clear_q,
  output logic                    isr_low_q,
  output logic                    isr_high_q,
  output logic [7:0]              enable_q
);

  localparam int N = tia_pkg::NUM_SRC;
  localparam int W = tia_pkg::IDX_W;

  // Priority register and decode state
  logic [7:0]         prio_q;
  logic [N-1:0]       src_req;
  logic [N-1:0]       src_en;
  logic [N-1:0]       src_prio;
  logic [N-1:0]       elig;
  logic [N-1:0]       elig_hi;
  logic [N-1:0]       elig_lo;
  logic               hi_ok;
  logic               lo_ok;
  logic               win_vld_d;
  logic [W-1:0]       win_idx_d;
  logic               win_hi_d;
  logic               win_vld_q;
  logic [W-1:0]       win_idx_q;
  logic               win_hi_q;
  logic               take;
  logic               svc_hi_q;
  logic [1:0]         cnt_q;
  tia_pkg::tia_state_e state_q;
  logic               end_call;
  logic               hi_busy;
  logic               lo_busy;

  // Lowest set index, the fixed order inside a level
  function automatic logic [W-1:0] first_set(
    input logic [N-1:0] v
  );
    logic [W-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = W'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Register write with byte and single-bit forms
  function automatic logic [7:0] sfr_upd(
    input logic [7:0]        old,
    input tia_pkg::tia_sfr_s s,
    input logic [7:0]        addr
  );
    logic [7:0] nv;
    nv = old;
    if (s.addr == addr) begin
      if (s.wr) begin
        nv = s.wdata;
      end else if (s.bit_wr) begin
        nv[s.bit_sel] = s.bit_val;
      end
    end
    return nv;
  endfunction : sfr_upd

  // Vector address for an order number
  function automatic logic [15:0] vec_of(
    input logic [W-1:0] idx
  );
    return tia_pkg::VEC_BASE +
      16'(tia_pkg::VEC_STEP * 16'(idx));
  endfunction : vec_of

  // Enable register, bit addressable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= tia_pkg::ENABLE_RST;
    end else begin
      enable_q <= sfr_upd(enable_q, sfr,
                          tia_pkg::ENABLE_ADDR);
    end
  end

  // Primary priority register, all low after reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_q <= tia_pkg::PRIO_RST;
    end else begin
      prio_q <= sfr_upd(prio_q, sfr, tia_pkg::PRIO_ADDR);
    end
  end

  // Read port, one clock behind the address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= tia_pkg::UNMAPPED_RD;
    end else if (sfr.addr == tia_pkg::ENABLE_ADDR) begin
      sfr_rdata_q <= enable_q;
    end else if (sfr.addr == tia_pkg::PRIO_ADDR) begin
      sfr_rdata_q <= prio_q | tia_pkg::PRIO_RD_FIXED;
    end else begin
      sfr_rdata_q <= tia_pkg::UNMAPPED_RD;
    end
  end

  // Request per order number; reserved slots never request
  always_comb begin
    src_req     = '0;
    src_req[0]  = ext_input0_pending;
    src_req[1]  = timer0_overflow_flag;
    src_req[2]  = ext_input1_pending;
    src_req[3]  = timer1_overflow_flag;
    src_req[4]  = |flags.uart;
    src_req[5]  = |flags.timer2;
    src_req[6]  = |flags.spi;
    src_req[7]  = flags.twowire_flag;
    src_req[9]  = flags.adc_window;
    src_req[10] = flags.adc_done;
    src_req[11] = |flags.pca;
    src_req[12] = |flags.comparator;
    src_req[14] = |flags.timer3;
  end

  // Masks and levels: primary bits low, extended bits above
  assign src_en = {enable_mask_extended,
                   enable_q[tia_pkg::PRIMARY_SRCS-1:0]};
  assign src_prio = {priority_level_extended,
                     prio_q[tia_pkg::PRIMARY_SRCS-1:0]};

  // Global enable gates every source
  assign elig = enable_q[tia_pkg::GLOBAL_EN_BIT] ?
                (src_req & src_en) : '0;
  assign elig_hi = elig & src_prio;
  assign elig_lo = elig & ~src_prio;

  // Preemption limits from the markers as they stand after this edge,
  // so a return frees the level for the very next instruction end and
  // a marker set at call end already blocks the following decode
  assign end_call = (state_q == tia_pkg::ST_CALL) && (cnt_q == 2'h0);
  assign hi_busy  = (isr_high_q && !reti_done) ||
                    (end_call && svc_hi_q);
  assign lo_busy  = (isr_low_q && !(reti_done && !isr_high_q)) ||
                    (end_call && !svc_hi_q);
  assign hi_ok = !hi_busy;
  assign lo_ok = !hi_busy && !lo_busy;

  // Winner: high level first, then order number
  always_comb begin
    win_vld_d = 1'b0;
    win_hi_d  = 1'b0;
    win_idx_d = '0;
    if (hi_ok && |elig_hi) begin
      win_vld_d = 1'b1;
      win_hi_d  = 1'b1;
      win_idx_d = first_set(elig_hi);
    end else if (lo_ok && |elig_lo) begin
      win_vld_d = 1'b1;
      win_idx_d = first_set(elig_lo);
    end
  end

  // Detection stage, refreshed every clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_vld_q <= 1'b0;
      win_hi_q  <= 1'b0;
      win_idx_q <= '0;
    end else begin
      win_vld_q <= win_vld_d;
      win_hi_q  <= win_hi_d;
      win_idx_q <= win_idx_d;
    end
  end

  // Take at an instruction end that is not the return itself
  assign take = (state_q == tia_pkg::ST_IDLE) && win_vld_q &&
                instr_end && !reti_done;

  // Call sequencer: four clocks of long call after detection
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= tia_pkg::ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        tia_pkg::ST_IDLE: begin
          if (take) begin
            state_q <= tia_pkg::ST_CALL;
            cnt_q   <= tia_pkg::CALL_LAST;
          end
        end
        tia_pkg::ST_CALL: begin
          if (cnt_q == 2'h0) begin
            state_q <= tia_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
      endcase
    end
  end

  // Call outputs: busy level, start pulse and vector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      call_busy_q  <= 1'b0;
      call_start_q <= 1'b0;
      call_vec_q   <= tia_pkg::RESET_VEC;
      svc_hi_q     <= 1'b0;
    end else begin
      call_start_q <= take;
      if (take) begin
        call_busy_q <= 1'b1;
        call_vec_q  <= vec_of(win_idx_q);
        svc_hi_q    <= win_hi_q;
      end else if (state_q == tia_pkg::ST_CALL &&
                   cnt_q == 2'h0) begin
        call_busy_q <= 1'b0;
      end
    end
  end

  // Hardware clear pulse for the four self-clearing flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hw_clear_q <= '0;
    end else begin
      hw_clear_q <= '0;
      if (take && win_idx_q < W'(tia_pkg::HW_CLR_SRCS)) begin
        hw_clear_q[win_idx_q[1:0]] <= 1'b1;
      end
    end
  end

  // In-service markers: set on vectoring, cleared on return
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      isr_low_q  <= 1'b0;
      isr_high_q <= 1'b0;
    end else if (state_q == tia_pkg::ST_CALL &&
                 cnt_q == 2'h0) begin
      if (svc_hi_q) begin
        isr_high_q <= 1'b1;
      end else begin
        isr_low_q <= 1'b1;
      end
    end else if (reti_done) begin
      if (isr_high_q) begin
        isr_high_q <= 1'b0;
      end else begin
        isr_low_q <= 1'b0;
      end
    end
  end

endmodule : tia_arbiter

// [testbench/tia_core_model.sv]
// Core sequencer and owner of the four single pending flags.
// Assumes the arbiter's ref_clk and rst_b; the bench sets the lengths.
`timescale 1ns/1ps
module tia_core_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Bench control
  input  wire logic [3:0] len_i,
  input  wire logic       reti_i,
  input  wire logic [3:0] set_i,
  // Arbiter side
  input  wire logic       call_busy_q,
  input  wire logic [3:0] hw_clear_q,
  output logic            instr_end,
  output logic            reti_done,
  output logic [3:0]      flag_q
);
  logic [3:0] cnt_q;
  // Instruction ends when its cycle count is used up
  assign instr_end = !call_busy_q && cnt_q == len_i - 4'h1;
  assign reti_done = instr_end && reti_i;
  // Cycle count, frozen while a call runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 4'h0;
    else if (instr_end) cnt_q <= 4'h0;
    else if (!call_busy_q) cnt_q <= cnt_q + 4'h1;
  end
  // Flags: a set in the clear cycle wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) flag_q <= 4'h0;
    else flag_q <= set_i | (flag_q & ~hw_clear_q);
  end
endmodule : tia_core_model

// [testbench/tia_arbiter_sva.sv]
// Checker of the arbiter's call, vector, clear and marker outputs.
// Assumes one clock domain; bound to the arbiter below.
`timescale 1ns/1ps
module tia_arbiter_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Core side
  input wire logic        instr_end,
  input wire logic        reti_done,
  input wire logic        call_busy_q,
  input wire logic [15:0] call_vec_q,
  input wire logic        call_start_q,
  // Status
  input wire logic [3:0]  hw_clear_q,
  input wire logic        isr_low_q,
  input wire logic        isr_high_q,
  input wire logic [7:0]  enable_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Call sequencing and vector shape
  property p_busy;
    $rose(call_busy_q) |-> call_start_q ##0 call_busy_q[*4] ##1 !call_busy_q;
  endproperty
  a_busy: assert property (p_busy) else $error("call length");
  property p_take;
    call_start_q |-> $past(instr_end) && !$past(reti_done);
  endproperty
  a_take: assert property (p_take) else $error("call take");
  property p_vec;
    call_start_q |-> call_vec_q[2:0] == 3'h3 && call_vec_q <= 16'h0073
      && call_vec_q != 16'h0043 && call_vec_q != 16'h006B;
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_clr;
    call_start_q |-> hw_clear_q ==
      (call_vec_q < 16'h0020 ? 4'h1 << call_vec_q[4:3] : 4'h0);
  endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
  property p_ea;
    call_start_q |-> $past(enable_q[7], 2);
  endproperty
  a_ea: assert property (p_ea) else $error("global enable");
  property p_high;
    call_start_q |-> !$past(isr_high_q);
  endproperty
  a_high: assert property (p_high) else $error("high preempted");
  property p_reti;
    reti_done |=> !call_start_q;
  endproperty
  a_reti: assert property (p_reti) else $error("call at return");
  property p_mark;
    $fell(call_busy_q) |-> isr_low_q || isr_high_q;
  endproperty
  a_mark: assert property (p_mark) else $error("marker");
  // Main scenarios
  c_call: cover property (call_start_q);
  c_pre: cover property (isr_low_q && isr_high_q);
  c_ret: cover property (reti_done);
endmodule : tia_arbiter_chk
bind tia_arbiter tia_arbiter_chk u_chk (.ref_clk, .rst_b, .instr_end,
  .reti_done, .call_busy_q, .call_vec_q, .call_start_q, .hw_clear_q,
  .isr_low_q, .isr_high_q, .enable_q);

// [testbench/two_level_interrupt_arbiter_bench.sv]
// Self-checking bench for the two-level interrupt arbiter.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/1ps
module two_level_interrupt_arbiter_bench;
  logic ref_clk, rst_b, reti_i, call_busy_q, call_start_q;
  logic isr_low_q, isr_high_q, instr_end, reti_done;
  logic [3:0] len_i, set_i, flag_q, hw_clear_q, s;
  logic [7:0] sfr_rdata_q, enable_q, ev, pv, r, ee, pe;
  logic [15:0] call_vec_q, v, e;
  tia_pkg::tia_sfr_s sfr;
  tia_pkg::tia_flags_s flags;
  logic [31:0] seed = 32'hC5B5;
  int fail_count, num_checks, n;
  // Design and core model
  tia_arbiter u_dut (.ref_clk, .rst_b, .sfr, .sfr_rdata_q,
    .enable_mask_extended(ee), .priority_level_extended(pe),
    .ext_input0_pending(flag_q[0]), .timer0_overflow_flag(flag_q[1]),
    .ext_input1_pending(flag_q[2]), .timer1_overflow_flag(flag_q[3]),
    .flags, .instr_end, .reti_done, .call_busy_q, .call_vec_q,
    .call_start_q, .hw_clear_q, .isr_low_q, .isr_high_q, .enable_q);
  tia_core_model u_core (.ref_clk, .rst_b, .len_i, .reti_i, .set_i,
    .call_busy_q, .hw_clear_q, .instr_end, .reti_done, .flag_q);
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected vector, FFFF when nothing may be taken
  function automatic logic [15:0] exp_vec();
    logic [14:0] m, h;
    m = {|flags.timer3, 1'b0, |flags.comparator, |flags.pca,
      flags.adc_done, flags.adc_window, 1'b0, flags.twowire_flag,
      |flags.spi, |flags.timer2, |flags.uart, s};
    m = m & {ee, ev[6:0]} & {15{ev[7]}};
    h = m & {pe, pv[6:0]};
    if (h != 15'h0) m = h;
    exp_vec = 16'hFFFF;
    for (int i = 14; i >= 0; i--)
      if (m[i]) exp_vec = tia_pkg::VEC_BASE + tia_pkg::VEC_STEP * 16'(i);
  endfunction : exp_vec
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic do_reset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
  endtask : do_reset
  // Register write; b selects a bit write of d[7] to bit d[2:0]
  task automatic wr(logic [7:0] a, logic [7:0] d, logic b);
    @(negedge ref_clk);
    sfr = '{addr: a, wr: !b, wdata: d, bit_wr: b, bit_sel: d[2:0],
      bit_val: d[7]};
    @(negedge ref_clk);
    sfr.wr = 1'b0;
    sfr.bit_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr.addr = a;
    @(negedge ref_clk);
    d = sfr_rdata_q;
  endtask : rd
  task automatic pulse(logic [3:0] m, logic rt);
    @(negedge ref_clk);
    set_i = m;
    reti_i = rt;
    @(negedge ref_clk);
    set_i = 4'h0;
    reti_i = 1'b0;
  endtask : pulse
  // Wait a bounded time for a call start
  task automatic wait_call(output logic [15:0] vv, output int k);
    vv = 16'hFFFF;
    for (k = 1; k < 30; k++) begin
      @(negedge ref_clk);
      if (call_start_q === 1'b1) begin
        vv = call_vec_q;
        break;
      end
    end
  endtask : wait_call
  task automatic call_chk(logic [3:0] m, logic rt, logic [15:0] x);
    pulse(m, rt);
    wait_call(v, n);
    chk("vec", v, x);
    repeat (tia_pkg::CALL_CYC) @(negedge ref_clk);
  endtask : call_chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {rst_b, reti_i, set_i, ee, pe} = '0;
    sfr = '0;
    flags = '0;
    len_i = 4'h1;
    for (int t = 0; t < 40; t++) begin
      flags = '0;
      do_reset();
      ee = 8'(rnd());
      pe = 8'(rnd());
      ev = 8'(rnd());
      pv = 8'(rnd());
      wr(8'hA8, ev, 1'b0);
      wr(8'hB8, pv, 1'b0);
      s = 4'(rnd());
      pulse(s, 1'b0);
      flags = tia_pkg::tia_flags_s'(19'(rnd()));
      e = exp_vec();
      wait_call(v, n);
      chk("arb", v, e);
      @(negedge ref_clk);
      chk("flag", flag_q, e < 16'h20 ? s & ~(4'h1 << e[4:3]) : s);
    end
    {ee, pe} = '0;
    flags = '0;
    do_reset();
    rd(8'hA8, r);
    chk("ie_rst", r, tia_pkg::ENABLE_RST);
    rd(8'hB8, r);
    chk("ip_rst", r, tia_pkg::PRIO_RD_FIXED);
    rd(8'hA9, r);
    chk("unmap", r, tia_pkg::UNMAPPED_RD);
    wr(8'hA8, 8'h0D, 1'b0);
    wr(8'hA8, 8'h87, 1'b1);
    wr(8'hA8, 8'h81, 1'b1);
    chk("ie", enable_q, 8'h8F);
    wr(8'hB8, 8'h02, 1'b0);
    rd(8'hB8, r);
    chk("ip", r, 8'h82);
    pulse(4'h1, 1'b0);
    wait_call(v, n);
    chk("lat", 16'(n), 16'(tia_pkg::DETECT_CYC + 1));
    repeat (tia_pkg::CALL_CYC) @(negedge ref_clk);
    call_chk(4'h2, 1'b0, 16'h000B);
    chk("mk", {isr_high_q, isr_low_q}, 2'b11);
    call_chk(4'h4, 1'b0, 16'hFFFF);
    call_chk(4'h0, 1'b1, 16'hFFFF);
    call_chk(4'h0, 1'b1, 16'h0013);
    // Return of five cycles, then a divide of eight
    @(negedge ref_clk);
    {set_i, len_i, reti_i} = {4'h1, 4'h5, 1'b1};
    @(negedge ref_clk);
    set_i = 4'h0;
    repeat (4) @(negedge ref_clk);
    {len_i, reti_i} = {4'h8, 1'b0};
    wait_call(v, n);
    len_i = 4'h1;
    chk("worst", 16'(n), 16'(tia_pkg::DIV_CYC));
    chk("wvec", v, 16'h0003);
    print_verdict();
  end
endmodule : two_level_interrupt_arbiter_bench
